// file: rtl/processor_status_led_signaller.sv
module processor_status_led_signaller #(
    parameter int unsigned DL_HALF   = status_led_pkg::DL_HALF,
    parameter int unsigned TERM_HALF = status_led_pkg::TERM_HALF,
    parameter int unsigned PULSE_CYC = status_led_pkg::PULSE_CYC,
    parameter int unsigned GAP_CYC   = status_led_pkg::GAP_CYC,
    parameter int unsigned NSRC      = 16
) (
    input  wire logic                                     I_CLK_SYS,
    input  wire logic                                     I_RESET,
    input  wire status_led_pkg::lamp_cmd_s                i_inv_cmd,
    input  wire status_led_pkg::lamp_cmd_s                i_rect_cmd,
    input  wire logic                                     i_inv_kick,
    input  wire logic                                     i_rect_kick,
    input  wire logic [NSRC*status_led_pkg::DAC_W-1:0]    i_diag_src,
    input  wire logic                                     i_sel_we,
    input  wire logic [2:0]                               i_sel_idx,
    input  wire logic [status_led_pkg::SEL_W-1:0]         i_sel_val,
    output status_led_pkg::lamp_s                         o_inverter_status_lamp,
    output status_led_pkg::lamp_s                         o_rectifier_status_lamp,
    output logic                                          o_inverter_watchdog_lamp,
    output logic                                          o_rectifier_watchdog_lamp,
    output logic                                          o_inv_download,
    output logic                                          o_rect_download,
    output logic [8*status_led_pkg::DAC_W-1:0]            o_diag_out
);
    localparam int unsigned DW = status_led_pkg::DAC_W;
    localparam int unsigned SW = status_led_pkg::SEL_W;

    // Per-side signalling state
    logic [31:0] tmr      [2];  // Phase timer
    logic        blink    [2];  // Blink phase
    logic [4:0]  pcnt     [2];  // Pulse half-steps done
    logic        in_gap   [2];  // Dark gap between bursts
    logic        green_ph [2];  // Port-number green phase
    logic        wdog     [2];  // Watchdog toggle
    logic [31:0] next_tmr      [2];
    logic        next_blink    [2];
    logic [4:0]  next_pcnt     [2];
    logic        next_in_gap   [2];
    logic        next_green_ph [2];
    logic        next_wdog     [2];
    status_led_pkg::lamp_s lamp      [2];
    status_led_pkg::lamp_s next_lamp [2];
    status_led_pkg::lamp_cmd_s cmd [2];
    logic kick [2];

    assign cmd[0]  = i_inv_cmd;
    assign cmd[1]  = i_rect_cmd;
    assign kick[0] = i_inv_kick;
    assign kick[1] = i_rect_kick;

    // Next-state for both lamps
    always_comb begin
        for (int s = 0; s < 2; s++) begin
            logic [31:0] half;
            logic [4:0]  target;
            logic        eff_dl;
            half   = 32'(TERM_HALF);
            target = 5'h00;
            // Missing firmware forces download blink
            eff_dl = !cmd[s].fw_present || cmd[s].mode == status_led_pkg::MODE_DOWNLOAD;
            next_tmr[s]      = tmr[s] + 32'h1;
            next_blink[s]    = blink[s];
            // Burst progress restarts whenever a non-burst mode is shown
            next_pcnt[s]     = '0;
            next_in_gap[s]   = 1'b0;
            next_green_ph[s] = 1'b0;
            next_wdog[s]     = kick[s] ? ~wdog[s] : wdog[s];
            next_lamp[s]     = '0;
            if (eff_dl || cmd[s].mode == status_led_pkg::MODE_TERMINAL) begin
                // Fixed-rate green blink
                half = eff_dl ? 32'(DL_HALF) : 32'(TERM_HALF);
                if (tmr[s] >= half - 32'h1) begin
                    next_tmr[s]   = '0;
                    next_blink[s] = ~blink[s];
                end
                next_lamp[s].green = blink[s];
            end else if (cmd[s].mode == status_led_pkg::MODE_RUN) begin
                // Solid modes keep the timer parked so the next pattern starts clean
                next_tmr[s]        = '0;
                next_lamp[s].green = 1'b1;
            end else if (cmd[s].mode == status_led_pkg::MODE_FAIL) begin
                next_tmr[s]      = '0;
                next_lamp[s].red = 1'b1;
            end else if (cmd[s].mode == status_led_pkg::MODE_OFF) begin
                next_tmr[s] = '0;
            end else begin
                // Counted burst codes carry their progress
                next_pcnt[s]     = pcnt[s];
                next_in_gap[s]   = in_gap[s];
                next_green_ph[s] = green_ph[s];
                unique case (cmd[s].mode)
                    status_led_pkg::MODE_USART_FAIL: target = {status_led_pkg::CNT_USART, 1'b0};
                    status_led_pkg::MODE_CRC_ERR:    target = {status_led_pkg::CNT_CRC, 1'b0};
                    default:                         target = {status_led_pkg::CNT_OVERFLOW, 1'b0};
                endcase
                if (green_ph[s]) begin
                    target = {2'b00, cmd[s].port == 2'h2 ? 2'h2 : 2'h1, 1'b0};
                end
                if (in_gap[s]) begin
                    // Long dark gap, then restart burst
                    if (tmr[s] >= 32'(GAP_CYC) - 32'h1) begin
                        next_tmr[s]    = '0;
                        next_in_gap[s] = 1'b0;
                    end
                end else begin
                    next_lamp[s].red   = !pcnt[s][0] && !green_ph[s];
                    next_lamp[s].green = !pcnt[s][0] && green_ph[s];
                    if (tmr[s] >= 32'(PULSE_CYC) - 32'h1) begin
                        next_tmr[s]  = '0;
                        next_pcnt[s] = pcnt[s] + 5'h01;
                        if (pcnt[s] + 5'h01 >= target) begin
                            next_pcnt[s] = '0;
                            if (cmd[s].mode == status_led_pkg::MODE_USART_FAIL && !green_ph[s]) begin
                                next_green_ph[s] = 1'b1;
                                next_in_gap[s]   = 1'b1;
                            end else begin
                                next_green_ph[s] = 1'b0;
                                next_in_gap[s]   = 1'b1;
                            end
                        end
                    end
                end
            end
        end
    end

    // Lamp state registers
    always_ff @(posedge I_CLK_SYS) begin
        for (int s = 0; s < 2; s++) begin
            if (I_RESET) begin
                // Dark lamps, idle timers
                tmr[s]      <= '0;
                blink[s]    <= 1'b0;
                pcnt[s]     <= '0;
                in_gap[s]   <= 1'b0;
                green_ph[s] <= 1'b0;
                wdog[s]     <= 1'b0;
                lamp[s]     <= '0;
            end else begin
                // Take the computed next values
                tmr[s]      <= next_tmr[s];
                blink[s]    <= next_blink[s];
                pcnt[s]     <= next_pcnt[s];
                in_gap[s]   <= next_in_gap[s];
                green_ph[s] <= next_green_ph[s];
                wdog[s]     <= next_wdog[s];
                lamp[s]     <= next_lamp[s];
            end
        end
    end

    assign o_inverter_status_lamp    = lamp[0];
    assign o_rectifier_status_lamp   = lamp[1];
    assign o_inverter_watchdog_lamp  = wdog[0];
    assign o_rectifier_watchdog_lamp = wdog[1];
    assign o_inv_download  = !i_inv_cmd.fw_present;
    assign o_rect_download = !i_rect_cmd.fw_present;

    // Diagnostic selector store, held across resets as nonvolatile
    logic [SW-1:0] sel      [8];
    logic [SW-1:0] next_sel [8];
    logic [8*DW-1:0] diag, next_diag;

    // Selector update and output mux
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            next_sel[k] = (i_sel_we && i_sel_idx == 3'(k)) ? i_sel_val : sel[k];
            // Wrap the selector into the source range at full width
            next_diag[k*DW +: DW] = i_diag_src[(32'(sel[k]) % NSRC)*DW +: DW];
        end
    end

    // Selector store is not cleared by reset
    always_ff @(posedge I_CLK_SYS) begin
        for (int k = 0; k < 8; k++) sel[k] <= next_sel[k];
        diag <= I_RESET ? '0 : next_diag;
    end
    assign o_diag_out = diag;

    // Edges the inverter lamp has held still in terminal blink
    logic [31:0] term_hold;
    logic [31:0] next_term_hold;

    // Restart on any green change or when terminal blink is left
    always_comb begin
        if (!i_inv_cmd.fw_present || i_inv_cmd.mode != status_led_pkg::MODE_TERMINAL) begin
            next_term_hold = '0;
        end else if (next_lamp[0].green != lamp[0].green) begin
            next_term_hold = '0;
        end else begin
            next_term_hold = term_hold + 32'h1;
        end
    end

    // Hold counter register
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            term_hold <= '0;
        end else begin
            term_hold <= next_term_hold;
        end
    end

    // Checks
    property p_run_green;
        @(posedge I_CLK_SYS) disable iff (I_RESET)
        (i_inv_cmd.fw_present && i_inv_cmd.mode == status_led_pkg::MODE_RUN)[*2] |->
            o_inverter_status_lamp.green && !o_inverter_status_lamp.red;
    endproperty
    a_run_green: assert property (p_run_green) else $error("run not green");
    property p_fail_red;
        @(posedge I_CLK_SYS) disable iff (I_RESET)
        (i_rect_cmd.fw_present && i_rect_cmd.mode == status_led_pkg::MODE_FAIL)[*2] |->
            o_rectifier_status_lamp.red && !o_rectifier_status_lamp.green;
    endproperty
    a_fail_red: assert property (p_fail_red) else $error("fail not red");
    property p_wdog;
        @(posedge I_CLK_SYS) disable iff (I_RESET)
        i_inv_kick |=> o_inverter_watchdog_lamp != $past(o_inverter_watchdog_lamp);
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog not toggled");
    property p_nofw;
        @(posedge I_CLK_SYS) disable iff (I_RESET)
        !i_inv_cmd.fw_present |=> !o_inverter_status_lamp.red;
    endproperty
    a_nofw: assert property (p_nofw) else $error("no firmware shows red");
    property p_blink_green;
        @(posedge I_CLK_SYS) disable iff (I_RESET)
        (i_inv_cmd.fw_present && i_inv_cmd.mode == status_led_pkg::MODE_TERMINAL)
            |=> !o_inverter_status_lamp.red;
    endproperty
    a_blink_green: assert property (p_blink_green) else $error("blink not green");
    property p_term_rate;
        @(posedge I_CLK_SYS) disable iff (I_RESET)
        term_hold < 32'(2 * TERM_HALF);
    endproperty
    a_term_rate: assert property (p_term_rate) else $error("terminal blink too slow");
    property p_rect_wdog;
        @(posedge I_CLK_SYS) disable iff (I_RESET)
        1'b1 |=> (o_rectifier_watchdog_lamp != $past(o_rectifier_watchdog_lamp))
            == $past(i_rect_kick);
    endproperty
    a_rect_wdog: assert property (p_rect_wdog) else $error("rectifier watchdog wrong");
endmodule

// file: include/status_led_pkg.sv
// How it works
// - Separate status lamp per processor side
// - Separate watchdog lamp per processor code
// - Download: green blink at half hertz
// - Terminal session: green blink at two hertz
// - Solid green running, solid red failed
// - Port self-test fail: nine red, port greens
// - Overflow fourteen red, CRC eleven red
// - No firmware enters download mode automatically
// - Settings retained in nonvolatile store
// - Eight assignable diagnostic analogue outputs
package status_led_pkg;
    // Clock rate
    localparam int unsigned CLK_HZ       = 100_000_000;
    // Blink periods, pulse step and gap lengths in milliseconds
    localparam int unsigned DL_PERIOD_MS = 2000;
    localparam int unsigned TERM_PERIOD_MS = 500;
    localparam int unsigned PULSE_MS     = 250;
    localparam int unsigned GAP_MS       = 2000;
    // Derived cycle counts (blink half periods, pulse step, gap)
    localparam int unsigned DL_HALF   = CLK_HZ / 1000 * DL_PERIOD_MS / 2;
    localparam int unsigned TERM_HALF = CLK_HZ / 1000 * TERM_PERIOD_MS / 2;
    localparam int unsigned PULSE_CYC = CLK_HZ / 1000 * PULSE_MS;
    localparam int unsigned GAP_CYC   = CLK_HZ / 1000 * GAP_MS;
    // Pulse counts
    localparam logic [3:0] CNT_USART    = 4'h9;
    localparam logic [3:0] CNT_CRC      = 4'hB;
    localparam logic [3:0] CNT_OVERFLOW = 4'hE;
    // Indicator mode codes
    typedef enum logic [2:0] {
        MODE_OFF, MODE_RUN, MODE_FAIL, MODE_DOWNLOAD, MODE_TERMINAL,
        MODE_USART_FAIL, MODE_CRC_ERR, MODE_OVERFLOW
    } mode_e;
    // One processor's command
    typedef struct packed {
        mode_e      mode;
        logic [1:0] port;
        logic       fw_present;
    } lamp_cmd_s;
    // Two colour lamp drive
    typedef struct packed {
        logic green;
        logic red;
    } lamp_s;
    localparam int unsigned DAC_W = 12;
    localparam int unsigned SEL_W = 4;
endpackage

// file: test/lamp_observer.sv
module lamp_observer #(
    parameter int unsigned GAP = 10
) (
    input  wire logic                  i_clk,
    input  wire status_led_pkg::lamp_s i_lamp,
    output logic [4:0]                 o_reds,
    output logic [4:0]                 o_greens,
    output logic [7:0]                 o_bursts
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0]            reds   = '0;  // Red flashes so far
    logic [4:0]            greens = '0;  // Green flashes so far
    int                    dark   = 0;   // Dark cycles in a row
    status_led_pkg::lamp_s last   = '0;  // Lamp one edge ago
    initial o_bursts = '0;
    // Count flashes, close a burst after a long dark spell
    always @(posedge i_clk) begin
        last <= i_lamp;
        if (i_lamp.red && !last.red) reds <= reds + 5'h1;
        if (i_lamp.green && !last.green) greens <= greens + 5'h1;
        dark <= (i_lamp === 2'b00) ? dark + 1 : 0;
        if (dark == GAP / 2 && (reds != 0 || greens != 0)) begin
            o_reds   <= reds;
            o_greens <= greens;
            o_bursts <= o_bursts + 8'h1;
            reds     <= '0;
            greens   <= '0;
        end
    end
endmodule

// file: test/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned DLH = 4, TMH = 2;
    logic                      clk, rst, ik, rk, we, w0, w1;
    status_led_pkg::lamp_cmd_s ic, rc;
    status_led_pkg::lamp_s     il, rl;
    logic                      iw, rw, idl, rdl;
    logic [191:0]              src;
    logic [95:0]               dout;
    logic [2:0]                idx;
    logic [3:0]                val, v;
    logic [3:0]                sel [8];
    logic [4:0]                reds, greens;
    logic [7:0]                bursts;
    int                        fail_count = 0, cmp_count = 0, n;
    int                        seed = 32'h569291d8;
    processor_status_led_signaller #(.DL_HALF(DLH), .TERM_HALF(TMH), .PULSE_CYC(3),
        .GAP_CYC(10)) u_processor_status_led_signaller (.I_CLK_SYS(clk), .I_RESET(rst),
        .i_inv_cmd(ic), .i_rect_cmd(rc), .i_inv_kick(ik), .i_rect_kick(rk),
        .i_diag_src(src), .i_sel_we(we), .i_sel_idx(idx), .i_sel_val(val),
        .o_inverter_status_lamp(il), .o_rectifier_status_lamp(rl),
        .o_inverter_watchdog_lamp(iw), .o_rectifier_watchdog_lamp(rw),
        .o_inv_download(idl), .o_rect_download(rdl), .o_diag_out(dout));
    // Service watcher on the rectifier lamp
    lamp_observer #(.GAP(10)) u_lamp_observer (.i_clk(clk), .i_lamp(rl),
        .o_reds(reds), .o_greens(greens), .o_bursts(bursts));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task automatic chk_num(string nm, logic [95:0] e, logic [95:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Lit time of one green blink on the inverter lamp
    task automatic blink(status_led_pkg::mode_e m, logic fw, int h);
        int c = 0, t = 0;
        @(posedge clk);
        ic <= '{m, 2'h0, fw};
        #1;
        while (il.green !== 1'b0 && t < 99) begin
            @(posedge clk) #1;
            t++;
        end
        while (il.green !== 1'b1 && t < 99) begin
            @(posedge clk) #1;
            t++;
        end
        while (il.green === 1'b1 && c < 99) begin
            @(posedge clk) #1;
            c++;
        end
        chk_num("blink half", 96'(h), 96'(c));
        chk_num("download flag", 96'(!fw), 96'(idl));
    endtask
    // Skip two bursts, then check a red burst and the one after it
    task automatic burst(status_led_pkg::mode_e m, logic [1:0] p, int r, int g);
        int k = 0, t = 0;
        logic [7:0] b;
        @(posedge clk);
        rc <= '{m, p, 1'b1};
        b = bursts;
        while (t < 3000 && !(k > 1 && reds != 0 && bursts != b)) begin
            if (bursts != b) k++;
            b = bursts;
            @(posedge clk) #1;
            t++;
        end
        b = bursts;
        chk_num("red burst", 96'(r), 96'(reds));
        chk_num("green in red burst", 96'h0, 96'(greens));
        while (t < 3000 && bursts == b) begin
            @(posedge clk) #1;
            t++;
        end
        chk_num("next reds", 96'(g != 0 ? 0 : r), 96'(reds));
        chk_num("next greens", 96'(g), 96'(greens));
    endtask
    task automatic diag_all();
        repeat (3) @(posedge clk);
        #1;
        for (int k = 0; k < 8; k++)
            chk_num("diag", 96'(src[sel[k]*12+:12]), 96'(dout[k*12+:12]));
    endtask
    initial begin
        #300000;
        fail_count++;
        end_of_test();
    end
    initial begin
        {rst, ik, rk, we, idx, val} = {1'b1, 10'h000};
        ic = '0;
        rc = '0;
        for (int i = 0; i < 6; i++) src[i*32+:32] = $random(seed);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        ic <= '{status_led_pkg::MODE_RUN, 2'h0, 1'b1};
        rc <= '{status_led_pkg::MODE_FAIL, 2'h0, 1'b1};
        repeat (6) @(posedge clk);
        #1;
        chk_num("inv lamp", 96'h2, 96'(il));
        chk_num("rect lamp", 96'h1, 96'(rl));
        blink(status_led_pkg::MODE_DOWNLOAD, 1'b1, DLH);
        blink(status_led_pkg::MODE_TERMINAL, 1'b1, TMH);
        blink(status_led_pkg::MODE_RUN, 1'b0, DLH);
        burst(status_led_pkg::MODE_CRC_ERR, 2'h0, 11, 0);
        burst(status_led_pkg::MODE_OVERFLOW, 2'h0, 14, 0);
        burst(status_led_pkg::MODE_USART_FAIL, 2'h1, 9, 1);
        burst(status_led_pkg::MODE_USART_FAIL, 2'h2, 9, 2);
        for (int j = 0; j < 4; j++) begin
            n = 1 + ($unsigned($random(seed)) % 8);
            @(posedge clk) #1;
            {w0, w1} = {iw, rw};
            @(posedge clk);
            {ik, rk} <= {1'b1, j[0]};
            repeat (n) @(posedge clk);
            {ik, rk} <= 2'b00;
            repeat (2) @(posedge clk);
            #1;
            chk_num("inv watchdog", 96'(w0 ^ n[0]), 96'(iw));
            chk_num("rect watchdog", 96'(w1 ^ (j[0] & n[0])), 96'(rw));
        end
        for (int k = 0; k < 8; k++) begin
            v = 4'($random(seed));
            sel[k] = v;
            @(posedge clk);
            {we, idx, val} <= {1'b1, 3'(k), v};
        end
        @(posedge clk);
        we <= 1'b0;
        diag_all();
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        diag_all();
        // Off mode goes dark; missing firmware raises the rectifier flag
        @(posedge clk);
        rc <= '{status_led_pkg::MODE_OFF, 2'h0, 1'b1};
        repeat (2) @(posedge clk);
        #1;
        chk_num("rect lamp off", 96'h0, 96'(rl));
        chk_num("rect download idle", 96'h0, 96'(rdl));
        @(posedge clk);
        rc <= '{status_led_pkg::MODE_OFF, 2'h0, 1'b0};
        @(posedge clk) #1;
        chk_num("rect download flag", 96'h1, 96'(rdl));
        end_of_test();
    end
endmodule
